// file: design/timestamped_reading_store.sv
// Purpose: reading store with relative or calendar timestamps
// Assumes: readings arrive on sys_clk; scroll keys are raw pins
// Notes:   store array, count and pointer keep no reset (retained)
// Behaviour
// - each reading stamped from one chosen source
// - first stored reading has absolute time zero
// - delta is time since previous stored reading
// - relative times kept in milliseconds
// - auto-empty off keeps first-entry reference until emptied or power-up
// - power-up restarts relative base at zero
// - local shows both; remote shows format choice
// - calendar stamp holds time, date, 10 ms
// - operator loads hour, minute, pm, date; not seconds
// - source change mid-run empties store, flags it
// - size 2 to 55000; zero empties store
// - auto-empty off accepts only 55000 or zero
// - active indicator from arm until count stored
// - abort stops storing at once
// - stored entries survive power removal
// - continuous mode wraps pointer to zero
// - recall and statistic indicators
// - held scroll steps 1, then 100, then 500
// - appending run stops full; full store emptied first
// - min and max report location and stamp
`timescale 1ns/1ps
module timestamped_reading_store #(
	parameter int MS_CYCLES   = store_pkg::MS_CYCLES,
	parameter int CS_CYCLES   = store_pkg::CS_CYCLES,
	parameter int REP_CYCLES  = store_pkg::REP_CYCLES,
	parameter int H100_CYCLES = store_pkg::H100_CYCLES,
	parameter int H500_CYCLES = store_pkg::H500_CYCLES
)(
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        reading_valid,
	input  wire logic [31:0] reading_data,
	input  wire logic        scroll_up_key,
	input  wire logic        scroll_down_key,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic      [1:0]  bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic      [31:0] rdata,
	output logic      [1:0]  rresp,
	output logic             rvalid,
	input  wire logic        rready,
	output logic             storage_indicator,
	output logic             recall_indicator,
	output logic             stat_indicator,
	output logic             cleared_indicator,
	output logic      [31:0] shown_reading,
	output logic      [31:0] shown_time_a,
	output logic      [31:0] shown_time_b
);
	// ==========================================================
	// declarations
	logic [7:0]  wr_addr;
	logic [31:0] wr_word;
	logic [3:0]  wstrb_q;
	logic        aw_got;
	logic        w_got;
	logic        wr_fire;
	logic [31:0] wr_val;
	logic [31:0] rd_word;
	logic        rd_ok;
	logic        auto_empty_setting;
	logic        time_source_select;
	logic        continuous;
	logic        relative_time_format_cmd;
	logic [15:0] size;
	logic        do_arm;
	logic        do_abort;
	logic        do_ack;
	logic        src_change;
	logic        auto_change;
	logic        size_wr;
	logic        store_empty;
	logic        store_wr;
	store_pkg::run_state_t run_state;
	logic [95:0] mem [0:int'(store_pkg::STORE_MAX)-1];
	logic [15:0] count;
	logic [15:0] wptr;
	logic        contents_type;
	logic [27:0] ms_div;
	logic [31:0] ms_now;
	logic [31:0] base_ms;
	logic [31:0] prev_abs;
	logic [31:0] stamp_a;
	logic [31:0] stamp_b;
	logic [23:0] time_now;
	logic [15:0] date_now;
	logic [31:0] min_val;
	logic [31:0] max_val;
	logic [15:0] min_loc;
	logic [15:0] max_loc;
	logic [63:0] min_stamp;
	logic [63:0] max_stamp;
	logic [15:0] index;
	logic [95:0] rd_q;
	logic [1:0]  up_sync;
	logic [1:0]  dn_sync;
	logic        held_d;
	logic [27:0] hold_cnt;
	logic [27:0] rep_cnt;
	logic [15:0] step;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		for (int i = 0; i < 4; i++)
			merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
	endfunction

	function automatic logic is_wr(input logic fire, input logic [7:0] a,
		input logic [7:0] off);
		is_wr = fire && a == off;
	endfunction

	// ==========================================================
	// write channel: address and data taken in either order
	assign wr_fire = aw_got && w_got && !bvalid;
	assign wr_val  = merge(32'h0, wr_word, wstrb_q);
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			awready <= 1'b1;
			wready  <= 1'b1;
			aw_got  <= 1'b0;
			w_got   <= 1'b0;
			wr_addr <= 8'h0;
			wr_word <= 32'h0;
			wstrb_q <= 4'h0;
			bvalid  <= 1'b0;
			bresp   <= store_pkg::RESP_OK;
		end else begin
			if (awvalid && awready) begin
				aw_got  <= 1'b1;
				awready <= 1'b0;
				wr_addr <= awaddr;
			end
			if (wvalid && wready) begin
				w_got   <= 1'b1;
				wready  <= 1'b0;
				wr_word <= wdata;
				wstrb_q <= wstrb;
			end
			if (wr_fire) begin
				bvalid <= 1'b1;
				bresp  <= (wr_addr > store_pkg::REG_CALD || wr_addr[1:0] != 2'h0)
					? store_pkg::RESP_ERR : store_pkg::RESP_OK;
			end
			if (bvalid && bready) begin
				bvalid  <= 1'b0;
				aw_got  <= 1'b0;
				w_got   <= 1'b0;
				awready <= 1'b1;
				wready  <= 1'b1;
			end
		end
	end

	// ==========================================================
	// read channel
	always_comb begin
		rd_ok = 1'b1;
		case (araddr)
			store_pkg::REG_CTRL: rd_word = {25'h0, relative_time_format_cmd,
				recall_indicator, continuous, time_source_select, auto_empty_setting, 2'h0};
			store_pkg::REG_SIZE: rd_word = {16'h0, size};
			store_pkg::REG_STATUS: rd_word = {27'h0, contents_type, cleared_indicator,
				stat_indicator, recall_indicator, storage_indicator};
			store_pkg::REG_COUNT:  rd_word = {16'h0, count};
			store_pkg::REG_INDEX:  rd_word = {16'h0, index};
			store_pkg::REG_VALUE:  rd_word = shown_reading;
			store_pkg::REG_STAMPA: rd_word = shown_time_a;
			store_pkg::REG_STAMPB: rd_word = shown_time_b;
			store_pkg::REG_REMOTE:
				rd_word = relative_time_format_cmd ? shown_time_b : shown_time_a;
			store_pkg::REG_LOCS:   rd_word = {max_loc, min_loc};
			store_pkg::REG_CALT:   rd_word = {8'h0, time_now};
			store_pkg::REG_CALD:   rd_word = {16'h0, date_now};
			default: begin
				rd_word = 32'h0;
				rd_ok   = 1'b0;
			end
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= 32'h0;
			rresp   <= store_pkg::RESP_OK;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rdata   <= rd_word;
			rresp   <= rd_ok ? store_pkg::RESP_OK : store_pkg::RESP_ERR;
		end else if (rvalid && rready) begin
			rvalid  <= 1'b0;
			arready <= 1'b1;
		end
	end

	// ==========================================================
	// control decode
	wire ctrl_wr = is_wr(wr_fire, wr_addr, store_pkg::REG_CTRL);
	assign size_wr     = is_wr(wr_fire, wr_addr, store_pkg::REG_SIZE);
	assign do_arm      = ctrl_wr && wr_val[store_pkg::C_ARM];
	assign do_abort    = ctrl_wr && wr_val[store_pkg::C_ABORT];
	assign do_ack      = ctrl_wr && wr_val[store_pkg::C_ACK];
	assign src_change  = ctrl_wr && wr_val[store_pkg::C_TSEL] != time_source_select;
	assign auto_change = ctrl_wr && wr_val[store_pkg::C_AUTO] != auto_empty_setting;
	// a full appending store is emptied before the next run
	assign store_empty = (size_wr && wr_val[15:0] == store_pkg::SIZE_EMPTY)
		|| (src_change && run_state == store_pkg::RUN_ACTIVE)
		|| (do_arm && (auto_empty_setting || count >= size))
		|| auto_change;
	assign store_wr = run_state == store_pkg::RUN_ACTIVE && reading_valid
		&& !store_empty && !do_abort;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			auto_empty_setting       <= 1'b1;
			time_source_select       <= 1'b0;
			continuous               <= 1'b0;
			recall_indicator         <= 1'b0;
			relative_time_format_cmd <= 1'b0;
		end else if (ctrl_wr) begin
			auto_empty_setting       <= wr_val[store_pkg::C_AUTO];
			time_source_select       <= wr_val[store_pkg::C_TSEL];
			continuous               <= wr_val[store_pkg::C_CONT];
			recall_indicator         <= wr_val[store_pkg::C_RECALL];
			relative_time_format_cmd <= wr_val[store_pkg::C_FMT];
		end
	end

	// size requests outside the allowed set are ignored
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			size <= store_pkg::STORE_MAX;
		else if (auto_change && !wr_val[store_pkg::C_AUTO])
			size <= store_pkg::STORE_MAX;
		else if (size_wr && auto_empty_setting && wr_val[15:0] >= store_pkg::STORE_MIN
			&& wr_val[15:0] <= store_pkg::STORE_MAX && wr_val[31:16] == 16'h0)
			size <= wr_val[15:0];
		else if (size_wr && wr_val[15:0] == store_pkg::STORE_MAX)
			size <= store_pkg::STORE_MAX;
	end

	// cleared flag: a new clear wins over the acknowledge
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			cleared_indicator <= 1'b0;
		else if (src_change && run_state == store_pkg::RUN_ACTIVE)
			cleared_indicator <= 1'b1;
		else if (do_ack)
			cleared_indicator <= 1'b0;
	end

	// ==========================================================
	// storage run
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			run_state <= store_pkg::RUN_IDLE;
		end else begin
			case (run_state)
				store_pkg::RUN_IDLE:
					if (do_arm && !do_abort)
						run_state <= store_pkg::RUN_ACTIVE;
				store_pkg::RUN_ACTIVE:
					if (do_abort)
						run_state <= store_pkg::RUN_IDLE;
					else if (store_wr && !continuous && count + 16'h1 >= size)
						run_state <= store_pkg::RUN_IDLE;
				default: run_state <= store_pkg::RUN_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			storage_indicator <= 1'b0;
		else
			storage_indicator <= run_state == store_pkg::RUN_ACTIVE;
	end

	// ==========================================================
	// relative time base
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ms_div <= 28'h0;
			ms_now <= 32'h0;
		end else if (ms_div == 28'(MS_CYCLES - 1)) begin
			ms_div <= 28'h0;
			ms_now <= ms_now + 32'h1;
		end else begin
			ms_div <= ms_div + 28'h1;
		end
	end

	calendar_clock #(
		.CS_CYCLES (CS_CYCLES)
	) u_calendar (
		.sys_clk   (sys_clk),
		.rst       (rst),
		.load_time (is_wr(wr_fire, wr_addr, store_pkg::REG_CALT)),
		.hour_in   (wr_val[15:12]),
		.minute_in (wr_val[11:6]),
		.pm_in     (wr_val[16]),
		.load_date (is_wr(wr_fire, wr_addr, store_pkg::REG_CALD)),
		.month_in  (wr_val[8:5]),
		.day_in    (wr_val[4:0]),
		.year_in   (wr_val[15:9]),
		.time_now  (time_now),
		.date_now  (date_now)
	);

	// absolute time stays tied to entry 0 until the store empties or power-up
	always_comb begin
		if (time_source_select) begin
			stamp_a = {8'h0, time_now};
			stamp_b = {16'h0, date_now};
		end else if (count == 16'h0) begin
			stamp_a = 32'h0;
			stamp_b = 32'h0;
		end else begin
			stamp_a = ms_now - base_ms;
			stamp_b = ms_now - base_ms - prev_abs;
		end
	end

	// base restarts at power-up, so old entries are not a reference
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			base_ms  <= 32'h0;
			prev_abs <= 32'h0;
		end else if (store_wr) begin
			if (count == 16'h0)
				base_ms <= ms_now;
			prev_abs <= stamp_a;
		end
	end

	// ==========================================================
	// store array, pointer and count carry no reset: they are retained
	always_ff @(posedge sys_clk) begin
		if (store_wr)
			mem[wptr] <= {reading_data, stamp_a, stamp_b};
		rd_q <= mem[(index < count) ? index : 16'h0];
	end

	always_ff @(posedge sys_clk) begin
		if (store_empty) begin
			count         <= 16'h0;
			wptr          <= 16'h0;
			contents_type <= time_source_select;
		end else if (store_wr) begin
			contents_type <= time_source_select;
			count <= (count >= size) ? count : count + 16'h1;
			wptr  <= (wptr + 16'h1 >= size) ? 16'h0 : wptr + 16'h1;
		end
	end

	// ==========================================================
	// minimum and maximum with location and stamp
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			min_val   <= 32'h0;
			max_val   <= 32'h0;
			min_loc   <= 16'h0;
			max_loc   <= 16'h0;
			min_stamp <= 64'h0;
			max_stamp <= 64'h0;
		end else if (store_wr) begin
			if (count == 16'h0 || $signed(reading_data) < $signed(min_val)) begin
				min_val   <= reading_data;
				min_loc   <= wptr;
				min_stamp <= {stamp_a, stamp_b};
			end
			if (count == 16'h0 || $signed(reading_data) > $signed(max_val)) begin
				max_val   <= reading_data;
				max_loc   <= wptr;
				max_stamp <= {stamp_a, stamp_b};
			end
		end
	end

	// ==========================================================
	// recall display: entries, then min at count, max at count+1
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			shown_reading  <= 32'h0;
			shown_time_a   <= 32'h0;
			shown_time_b   <= 32'h0;
			stat_indicator <= 1'b0;
		end else begin
			stat_indicator <= recall_indicator && index >= count;
			if (index < count) begin
				{shown_reading, shown_time_a, shown_time_b} <= rd_q;
			end else if (index == count) begin
				{shown_time_a, shown_time_b} <= min_stamp;
				shown_reading <= min_val;
			end else begin
				{shown_time_a, shown_time_b} <= max_stamp;
				shown_reading <= max_val;
			end
		end
	end

	// ==========================================================
	// scroll keys; raw pins pass two flip-flops first
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			up_sync <= 2'h0;
			dn_sync <= 2'h0;
		end else begin
			up_sync <= {up_sync[0], scroll_up_key};
			dn_sync <= {dn_sync[0], scroll_down_key};
		end
	end

	// step grows while held, drops back to one on release
	assign step = (hold_cnt >= 28'(H500_CYCLES)) ? store_pkg::STEP_BIG
		: (hold_cnt >= 28'(H100_CYCLES)) ? store_pkg::STEP_MID : store_pkg::STEP_ONE;
	wire held = up_sync[1] || dn_sync[1];
	wire move = recall_indicator && held && (!held_d || rep_cnt == 28'(REP_CYCLES - 1));

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			held_d   <= 1'b0;
			hold_cnt <= 28'h0;
			rep_cnt  <= 28'h0;
		end else begin
			held_d <= held;
			if (!held) begin
				hold_cnt <= 28'h0;
				rep_cnt  <= 28'h0;
			end else begin
				if (hold_cnt < 28'(H500_CYCLES))
					hold_cnt <= hold_cnt + 28'h1;
				rep_cnt <= move ? 28'h0 : rep_cnt + 28'h1;
			end
		end
	end

	// index runs 0..count+1 so both statistic entries are reachable
	wire [15:0] last = count + 16'h1;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			index <= 16'h0;
		else if (is_wr(wr_fire, wr_addr, store_pkg::REG_INDEX))
			index <= (wr_val[15:0] > last) ? last : wr_val[15:0];
		else if (move && up_sync[1])
			index <= (index + step > last || index + step < index) ? last : index + step;
		else if (move)
			index <= (index >= step) ? index - step : 16'h0;
	end
endmodule

// file: common/store_pkg.sv
// Purpose: shared constants for the timestamped reading store
// Assumes: 50 MHz system clock, AXI4-Lite register access
// Notes:   times are kept in their own unit, cycle counts derive from them
package store_pkg;
	// ==========================================================
	// timing
	localparam int CLK_NS      = 20;
	localparam int MS_NS       = 1000000;
	localparam int CS_MS       = 10;
	localparam int REPEAT_MS   = 200;
	localparam int HOLD100_MS  = 2000;
	localparam int HOLD500_MS  = 4000;
	localparam int MS_CYCLES   = MS_NS / CLK_NS;
	localparam int CS_CYCLES   = CS_MS * MS_CYCLES;
	localparam int REP_CYCLES  = REPEAT_MS * MS_CYCLES;
	localparam int H100_CYCLES = HOLD100_MS * MS_CYCLES;
	localparam int H500_CYCLES = HOLD500_MS * MS_CYCLES;
	// ==========================================================
	// store sizing and scroll steps
	localparam logic [15:0] STORE_MAX  = 16'hd6d8;
	localparam logic [15:0] STORE_MIN  = 16'h0002;
	localparam logic [15:0] SIZE_EMPTY = 16'h0000;
	localparam logic [15:0] STEP_ONE   = 16'h0001;
	localparam logic [15:0] STEP_MID   = 16'h0064;
	localparam logic [15:0] STEP_BIG   = 16'h01f4;
	// ==========================================================
	// register offsets
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_SIZE   = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_COUNT  = 8'h0c;
	localparam logic [7:0] REG_INDEX  = 8'h10;
	localparam logic [7:0] REG_VALUE  = 8'h14;
	localparam logic [7:0] REG_STAMPA = 8'h18;
	localparam logic [7:0] REG_STAMPB = 8'h1c;
	localparam logic [7:0] REG_REMOTE = 8'h20;
	localparam logic [7:0] REG_LOCS   = 8'h24;
	localparam logic [7:0] REG_CALT   = 8'h28;
	localparam logic [7:0] REG_CALD   = 8'h2c;
	// ==========================================================
	// control bit positions and response codes
	localparam int C_ARM    = 0;
	localparam int C_ABORT  = 1;
	localparam int C_AUTO   = 2;
	localparam int C_TSEL   = 3;
	localparam int C_CONT   = 4;
	localparam int C_RECALL = 5;
	localparam int C_FMT    = 6;
	localparam int C_ACK    = 7;
	localparam logic [1:0] RESP_OK  = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;
	// ==========================================================
	// calendar limits and reset values
	localparam logic [6:0] CS_LAST   = 7'h63;
	localparam logic [5:0] SEC_LAST  = 6'h3b;
	localparam logic [3:0] HOUR_NOON = 4'hc;
	localparam logic [3:0] HOUR_PRE  = 4'hb;
	localparam logic [3:0] MONTH_DEC = 4'hc;
	localparam logic [6:0] YEAR_LAST = 7'h63;
	localparam logic [4:0] DAY_FIRST = 5'h01;
	localparam logic [3:0] MON_FIRST = 4'h1;
	typedef enum logic {RUN_IDLE = 1'b0, RUN_ACTIVE = 1'b1} run_state_t;
endpackage

// file: design/calendar_clock.sv
// Purpose: time-of-day and date counter with 10 ms resolution
// Assumes: one tick every CS_CYCLES system clocks
// Notes:   hour is 1..12 with a separate pm flag
`timescale 1ns/1ps
module calendar_clock #(
	parameter int CS_CYCLES = store_pkg::CS_CYCLES
)(
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        load_time,
	input  wire logic [3:0]  hour_in,
	input  wire logic [5:0]  minute_in,
	input  wire logic        pm_in,
	input  wire logic        load_date,
	input  wire logic [3:0]  month_in,
	input  wire logic [4:0]  day_in,
	input  wire logic [6:0]  year_in,
	output logic      [23:0] time_now,
	output logic      [15:0] date_now
);
	logic [27:0] div;
	logic        tick;
	logic [6:0]  cs;
	logic [5:0]  sec;
	logic [5:0]  minute;
	logic [3:0]  hour;
	logic        pm;
	logic [4:0]  day;
	logic [3:0]  month;
	logic [6:0]  year;
	logic        day_roll;

	function automatic logic [4:0] month_days(input logic [3:0] m, input logic [6:0] y);
		case (m)
			4'h2: month_days = (y[1:0] == 2'h0) ? 5'h1d : 5'h1c;
			4'h4, 4'h6, 4'h9, 4'hb: month_days = 5'h1e;
			default: month_days = 5'h1f;
		endcase
	endfunction

	assign time_now = {pm, hour, minute, sec, cs};
	assign date_now = {year, month, day};
	assign day_roll = tick && cs == store_pkg::CS_LAST && sec == store_pkg::SEC_LAST
		&& minute == store_pkg::SEC_LAST && hour == store_pkg::HOUR_PRE && pm;

	// ==========================================================
	// hundredths tick
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			div  <= 28'h0;
			tick <= 1'b0;
		end else begin
			tick <= div == 28'(CS_CYCLES - 1);
			div  <= (div == 28'(CS_CYCLES - 1)) ? 28'h0 : div + 28'h1;
		end
	end

	// ==========================================================
	// time of day; seconds are only ever counted, never loaded
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cs     <= 7'h0;
			sec    <= 6'h0;
			minute <= 6'h0;
			hour   <= store_pkg::HOUR_NOON;
			pm     <= 1'b0;
		end else if (load_time) begin
			hour   <= hour_in;
			minute <= minute_in;
			pm     <= pm_in;
		end else if (tick) begin
			cs <= (cs == store_pkg::CS_LAST) ? 7'h0 : cs + 7'h1;
			if (cs == store_pkg::CS_LAST) begin
				sec <= (sec == store_pkg::SEC_LAST) ? 6'h0 : sec + 6'h1;
				if (sec == store_pkg::SEC_LAST) begin
					minute <= (minute == store_pkg::SEC_LAST) ? 6'h0 : minute + 6'h1;
					if (minute == store_pkg::SEC_LAST) begin
						hour <= (hour == store_pkg::HOUR_NOON) ? 4'h1 : hour + 4'h1;
						if (hour == store_pkg::HOUR_PRE)
							pm <= !pm;
					end
				end
			end
		end
	end

	// ==========================================================
	// date
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			day   <= store_pkg::DAY_FIRST;
			month <= store_pkg::MON_FIRST;
			year  <= 7'h0;
		end else if (load_date) begin
			day   <= day_in;
			month <= month_in;
			year  <= year_in;
		end else if (day_roll) begin
			if (day >= month_days(month, year)) begin
				day <= store_pkg::DAY_FIRST;
				if (month == store_pkg::MONTH_DEC) begin
					month <= store_pkg::MON_FIRST;
					year  <= (year == store_pkg::YEAR_LAST) ? 7'h0 : year + 7'h1;
				end else begin
					month <= month + 4'h1;
				end
			end else begin
				day <= day + 5'h1;
			end
		end
	end
endmodule

// file: tb/reading_feed.sv
// Purpose: measurement path model feeding readings
// Assumes: one reading every 50 clocks while enabled
// Notes:   data lines toggle between readings, never hold
`timescale 1ns/1ps
module reading_feed (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        en,
	output logic             reading_valid,
	output logic      [31:0] reading_data
);
	// ====
	// paced readings
	logic [5:0] gap;
	logic [7:0] seq;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			gap <= 6'h00;
			seq <= 8'h00;
			reading_valid <= 1'b0;
			reading_data <= 32'h0;
		end else begin
			reading_valid <= en && gap == 6'h31;
			reading_data <= (en && gap == 6'h31) ? {24'h000001, seq} : ~reading_data;
			gap <= (!en || gap == 6'h31) ? 6'h00 : gap + 6'h01;
			seq <= !en ? 8'h00 : seq + {7'h00, gap == 6'h31};
		end
	end
endmodule

// file: tb/timestamped_reading_store_properties.sv
// Purpose: port checker for the reading store
// Assumes: one clock domain
// Notes:   sees top ports only
`timescale 1ns/1ps
module store_checker (
	input wire logic        sys_clk, rst, awvalid, awready, wvalid, wready, bvalid, bready,
	input wire logic        arvalid, arready, rvalid, rready, storage_indicator,
	input wire logic        recall_indicator, stat_indicator, cleared_indicator,
	input wire logic [7:0]  awaddr,
	input wire logic [3:0]  wstrb,
	input wire logic [31:0] wdata, rdata,
	input wire logic [1:0]  bresp
);
	// ====
	// write and read answers, flags
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence s_wr; awvalid && awready && wvalid && wready; endsequence
	sequence s_ctl; s_wr ##0 (awaddr == store_pkg::REG_CTRL && wstrb[0]); endsequence
	property p_bans; s_wr |-> ##2 bvalid; endproperty
	a_bans: assert property (p_bans) else $error("no write answer");
	property p_rans; arvalid && arready |=> rvalid; endproperty
	a_rans: assert property (p_rans) else $error("no read answer");
	property p_bhold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
	a_bhold: assert property (p_bhold) else $error("write answer dropped");
	property p_rhold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
	a_rhold: assert property (p_rhold) else $error("read answer dropped");
	property p_ack; $fell(cleared_indicator) && !$past(rst) |-> bvalid; endproperty
	a_ack: assert property (p_ack) else $error("cleared flag fell alone");
	property p_abort; s_ctl ##0 (wdata[1] && !wdata[0]) |-> ##[1:3] !storage_indicator; endproperty
	a_abort: assert property (p_abort) else $error("abort ignored");
	property p_recall; s_ctl ##0 wdata[5] |-> ##[1:3] recall_indicator; endproperty
	a_recall: assert property (p_recall) else $error("recall flag missing");
	property p_stat; stat_indicator |-> recall_indicator || $past(recall_indicator); endproperty
	a_stat: assert property (p_stat) else $error("stat flag outside recall");
endmodule
bind timestamped_reading_store store_checker u_chk (.sys_clk, .rst, .awvalid, .awready,
	.wvalid, .wready, .bvalid, .bready, .arvalid, .arready, .rvalid, .rready,
	.storage_indicator, .recall_indicator, .stat_indicator, .cleared_indicator, .awaddr,
	.wstrb, .wdata, .rdata, .bresp);

// file: tb/timestamped_reading_store_bench.sv
// Purpose: bench for the reading store
// Assumes: shortened timing parameters
// Notes:   down key held briefly during recall
`timescale 1ns/1ps
module timestamped_reading_store_bench;
	logic sys_clk = 0, rst = 1, en = 0, arvalid = 0, awvalid = 0, wvalid = 0;
	logic bready = 0, rready = 0, reading_valid, storage_indicator, recall_indicator;
	logic stat_indicator, cleared_indicator, awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, reading_data, got;
	logic [1:0] bresp, rresp;
	logic up_key = 0, dn_key = 0;
	logic [3:0] wstrb = 4'hf;
	int fail_count = 0, checks = 0;
	always #10 sys_clk = ~sys_clk;
	reading_feed feed (.sys_clk, .rst, .en, .reading_valid, .reading_data);
	timestamped_reading_store #(.MS_CYCLES(10), .CS_CYCLES(20), .REP_CYCLES(8),
		.H100_CYCLES(40), .H500_CYCLES(80)) dut (.sys_clk, .rst, .reading_valid,
		.reading_data, .scroll_up_key(up_key), .scroll_down_key(dn_key), .awaddr, .awvalid,
		.awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
		.araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .storage_indicator,
		.recall_indicator, .stat_indicator, .cleared_indicator, .shown_reading(),
		.shown_time_a(), .shown_time_b());
	// ====
	// bus tasks
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge sys_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		logic [1:0] r;
		rd(a, got, r);
		cmp(got, e);
	endtask
	task automatic until_store(input logic v);
		for (int n = 0; n < 600 && storage_indicator !== v; n++) @(posedge sys_clk);
		cmp({31'h0, storage_indicator}, {31'h0, v});
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (30000) @(posedge sys_clk);
		fail_count++;
		wrap_up;
	end
	// ====
	// tests
	initial begin
		logic [1:0] r;
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		// emptied first: count has no reset
		wr(8'h04, 32'h0);
		rc(8'h0c, 32'h0);
		wr(8'h00, 32'h4);
		// upper lane masked off, so only 3 lands
		wstrb <= 4'h1;
		wr(8'h04, 32'hff03);
		wstrb <= 4'hf;
		wr(8'h00, 32'h5);
		until_store(1'b1);
		en <= 1'b1;
		until_store(1'b0);
		en <= 1'b0;
		rc(8'h0c, 32'h3);
		$display("test store done");
		wr(8'h00, 32'h24);
		wr(8'h10, 32'h0);
		rc(8'h18, 32'h0);
		wr(8'h10, 32'h2);
		rc(8'h14, 32'h102);
		rc(8'h18, 32'ha);
		rc(8'h1c, 32'h5);
		rc(8'h20, 32'ha);
		wr(8'h00, 32'h64);
		rc(8'h20, 32'h5);
		wr(8'h10, 32'h3);
		rc(8'h08, 32'h6);
		// held 12 cycles: one move at press, one repeat
		dn_key <= 1'b1;
		repeat (12) @(posedge sys_clk);
		dn_key <= 1'b0;
		repeat (4) @(posedge sys_clk);
		rc(8'h10, 32'h1);
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		rc(8'h0c, 32'h3);
		$display("test recall done");
		wr(8'h00, 32'h4);
		wr(8'h04, 32'h64);
		wr(8'h00, 32'h5);
		en <= 1'b1;
		repeat (120) @(posedge sys_clk);
		en <= 1'b0;
		wr(8'h00, 32'hc);
		rc(8'h0c, 32'h0);
		cmp({31'h0, cleared_indicator}, 32'h1);
		wr(8'h00, 32'ha);
		en <= 1'b1;
		repeat (150) @(posedge sys_clk);
		en <= 1'b0;
		cmp({31'h0, storage_indicator}, 32'h0);
		rc(8'h0c, 32'h0);
		wr(8'h00, 32'h8c);
		cmp({31'h0, cleared_indicator}, 32'h0);
		$display("test clear done");
		wr(8'h00, 32'h8);
		wr(8'h04, 32'h5);
		rc(8'h04, {16'h0, store_pkg::STORE_MAX});
		rd(8'h30, got, r);
		cmp({30'h0, r}, {30'h0, store_pkg::RESP_ERR});
		cmp(got, 32'h0);
		$display("test sizing done");
		wrap_up;
	end
endmodule
